// >>> core/program_memory_data_read.sv
module program_memory_data_read
  import pm_data_pkg::*;
(
  // clock, reset and enable
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic en_i,
  // core request
  input wire logic req_valid_i,
  input wire core_req_s req_i,
  input wire logic [PADDR_W-1:0] pc_i,
  output logic req_ready_o,
  // results
  output logic done_o,
  output logic [DATA_W-1:0] acc_o,
  output logic pc_load_o,
  output logic [PADDR_W-1:0] pc_target_o,
  // program memory read port
  output logic pm_rd_o,
  output logic [PADDR_W-1:0] pm_addr_o,
  input wire logic [PWORD_W-1:0] pm_rdata_i,
  // data memory port
  output dm_req_s dm_o,
  input wire logic [DATA_W-1:0] dm_rdata_i
);
  // --------------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------------
  logic pm_space;
  logic [PADDR_W-1:0] pm_addr;
  state_e state_reg, state_next;
  logic [DATA_W-1:0] acc_reg;
  logic done_reg, pc_load_reg;
  logic [PADDR_W-1:0] pc_target_reg, pm_addr_reg;
  logic [1:0] wait_reg;

  pm_space_decode u_dec (
    .file_select_pointer_i(req_i.file_select_pointer),
    .pm_space_o(pm_space),
    .pm_addr_o(pm_addr)
  );

  wire logic take = en_i && req_valid_i && (state_reg == ST_IDLE);
  wire logic is_move = take && (req_i.op == OP_MOVE_INDIRECT);
  wire logic pm_move = is_move && pm_space;
  wire logic dm_move = is_move && !pm_space;
  // program space writes are dropped
  wire logic dm_write = take && (req_i.op == OP_WRITE_INDIRECT) && !pm_space;
  wire logic [PADDR_W-1:0] branch_target =
    PADDR_W'(pc_i + PADDR_W'(acc_reg));

  assign req_ready_o = en_i && (state_reg == ST_IDLE);
  assign done_o = done_reg;
  assign acc_o = acc_reg;
  assign pc_load_o = pc_load_reg;
  assign pc_target_o = pc_target_reg;
  assign pm_rd_o = (state_reg == ST_PM_WAIT);
  assign pm_addr_o = pm_addr_reg;
  assign dm_o.dm_rd = dm_move;
  assign dm_o.dm_wr = dm_write;
  assign dm_o.dm_addr = req_i.file_select_pointer;
  assign dm_o.dm_wdata = req_i.data;

  // --------------------------------------------------------------------------
  // state machine
  // --------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (pm_move) begin
          state_next = ST_PM_WAIT;
        end else if (dm_move) begin
          state_next = ST_DM_WAIT;
        end
      end
      ST_PM_WAIT: begin
        if (wait_reg == EXTRA_CYCLES) begin
          state_next = ST_IDLE;
        end
      end
      ST_DM_WAIT: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= ST_IDLE;
      wait_reg <= 2'h0;
      pm_addr_reg <= PC_RESET;
    end else if (en_i) begin
      state_reg <= state_next;
      wait_reg <= (state_reg == ST_PM_WAIT) ? 2'(wait_reg + 2'h1) : 2'h0;
      if (pm_move) begin
        pm_addr_reg <= pm_addr;
      end
    end
  end

  // --------------------------------------------------------------------------
  // accumulator and completion
  // --------------------------------------------------------------------------
  wire logic pm_finish = (state_reg == ST_PM_WAIT) && (wait_reg == EXTRA_CYCLES);
  wire logic simple_done = take && (req_i.op != OP_MOVE_INDIRECT) && (req_i.op != OP_NONE);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_reg <= ACC_RESET;
      done_reg <= 1'b0;
      pc_load_reg <= 1'b0;
      pc_target_reg <= PC_RESET;
    end else if (en_i) begin
      done_reg <= pm_finish || (state_reg == ST_DM_WAIT) || simple_done;
      pc_load_reg <= take && (req_i.op == OP_BRANCH_REL);
      if (take && (req_i.op == OP_BRANCH_REL)) begin
        pc_target_reg <= branch_target;
      end
      if (pm_finish) begin
        acc_reg <= pm_rdata_i[DATA_W-1:0];
      end else if (state_reg == ST_DM_WAIT) begin
        acc_reg <= dm_rdata_i;
      end else if (take && (req_i.op == OP_RETURN_LITERAL)) begin
        acc_reg <= req_i.data;
      end
    end
  end
endmodule : program_memory_data_read

// >>> shared/pm_data_pkg.sv
package pm_data_pkg;
  // --------------------------------------------------------------------------
  // widths
  // --------------------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PWORD_W = 14;
  localparam int unsigned PADDR_W = 15;
  localparam int unsigned PTR_W = 16;
  localparam int unsigned PM_SEL_BIT = 15;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [PADDR_W-1:0] PC_RESET = 15'h0000;
  // one extra instruction cycle for a program memory data read
  localparam logic [1:0] EXTRA_CYCLES = 2'h1;

  // --------------------------------------------------------------------------
  // operations
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_MOVE_INDIRECT = 3'h1,
    OP_WRITE_INDIRECT = 3'h2,
    OP_BRANCH_REL = 3'h3,
    OP_RETURN_LITERAL = 3'h4
  } op_e;

  typedef struct packed {
    op_e op;
    logic [PTR_W-1:0] file_select_pointer;
    logic [DATA_W-1:0] data;
  } core_req_s;

  typedef struct packed {
    logic dm_rd;
    logic dm_wr;
    logic [PTR_W-1:0] dm_addr;
    logic [DATA_W-1:0] dm_wdata;
  } dm_req_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PM_WAIT = 3'b010,
    ST_DM_WAIT = 3'b100
  } state_e;
endpackage : pm_data_pkg

// >>> core/pm_space_decode.sv
module pm_space_decode
  import pm_data_pkg::*;
(
  // pointer in
  input wire logic [PTR_W-1:0] file_select_pointer_i,
  // decode out
  output logic pm_space_o,
  output logic [PADDR_W-1:0] pm_addr_o
);
  assign pm_space_o = file_select_pointer_i[PM_SEL_BIT];
  assign pm_addr_o = file_select_pointer_i[PADDR_W-1:0];
endmodule : pm_space_decode

// >>> testbench/pm_data_chk.sv
module pm_data_chk
  import pm_data_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic req_valid_i,
  input wire core_req_s req_i,
  input wire logic [PADDR_W-1:0] pc_i,
  input wire logic req_ready_o,
  input wire logic done_o,
  input wire logic [DATA_W-1:0] acc_o,
  input wire logic pc_load_o,
  input wire logic [PADDR_W-1:0] pc_target_o,
  input wire logic pm_rd_o,
  input wire logic [PWORD_W-1:0] pm_rdata_i,
  input wire dm_req_s dm_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire tk = req_valid_i && req_ready_o;
  wire pm = req_i.file_select_pointer[PM_SEL_BIT];
  wire mv = tk && pm && req_i.op == OP_MOVE_INDIRECT;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  property p_sel; mv |=> pm_rd_o; endproperty
  a_sel: assert property (p_sel) else $error("no program read");
  property p_low; $fell(pm_rd_o) |-> acc_o == $past(pm_rdata_i[7:0]); endproperty
  a_low: assert property (p_low) else $error("bad low byte");
  property p_wr; tk && pm && req_i.op == OP_WRITE_INDIRECT |-> !dm_o.dm_wr ##1 done_o; endproperty
  a_wr: assert property (p_wr) else $error("program write leaked");
  property p_ext; mv |=> !done_o [*2] ##1 done_o; endproperty
  a_ext: assert property (p_ext) else $error("bad read length");
  property p_br;
    tk && req_i.op == OP_BRANCH_REL |=> pc_load_o && pc_target_o == $past(pc_i) + {7'h00, $past(acc_o)};
  endproperty
  a_br: assert property (p_br) else $error("bad branch");
  c_pm: cover property (mv);
  c_wr: cover property (tk && req_i.op == OP_WRITE_INDIRECT);
  c_br: cover property (pc_load_o);
endmodule : pm_data_chk

// >>> testbench/pm_flash_model.sv
module pm_flash_model
  import pm_data_pkg::*;
(
  input wire logic pm_rd_i,
  input wire logic [PADDR_W-1:0] addr_i,
  output logic [PWORD_W-1:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // inverted when idle so stale data never looks valid
  wire [PWORD_W-1:0] word = {addr_i[13:8], addr_i[7:0] ^ 8'h5a};
  assign rdata_o = pm_rd_i ? word : ~word;
endmodule : pm_flash_model

// >>> testbench/program_memory_data_read_tb_top.sv
module program_memory_data_read_tb_top;
  import pm_data_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, resetn_i = 0, req_valid_i = 0, req_ready_o, done_o, pc_load_o, pm_rd_o;
  logic en_i = 1;
  core_req_s req_i = '0;
  logic [14:0] pc_i = '0, pc_target_o, pm_addr_o;
  logic [7:0] acc_o, dm_rdata_i = 8'h3c;
  logic [13:0] pm_rdata_i;
  dm_req_s dm_o;
  int errors = 0, comparisons = 0;
  initial forever #2.5 clk_i = ~clk_i;
  program_memory_data_read u_program_memory_data_read (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .en_i(en_i),
    .req_valid_i(req_valid_i),
    .req_i(req_i),
    .pc_i(pc_i),
    .req_ready_o(req_ready_o),
    .done_o(done_o),
    .acc_o(acc_o),
    .pc_load_o(pc_load_o),
    .pc_target_o(pc_target_o),
    .pm_rd_o(pm_rd_o),
    .pm_addr_o(pm_addr_o),
    .pm_rdata_i(pm_rdata_i),
    .dm_o(dm_o),
    .dm_rdata_i(dm_rdata_i)
  );
  pm_flash_model u_pm_flash_model (.pm_rd_i(pm_rd_o), .addr_i(pm_addr_o), .rdata_o(pm_rdata_i));
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // issue one request, expect done after n edges
  task automatic go(op_e op, logic [15:0] p, int n);
    @(posedge clk_i) #1;
    req_i = '{op, p, 8'h00};
    req_valid_i = 1;
    #1 chk(dm_o.dm_wr, op == OP_WRITE_INDIRECT && !p[15]);
    chk(dm_o.dm_rd, op == OP_MOVE_INDIRECT && !p[15]);
    @(posedge clk_i) #1;
    req_valid_i = 0;
    chk(pm_rd_o, op == OP_MOVE_INDIRECT && p[15]);
    chk(req_ready_o, n == 1);
    repeat (n - 1) begin
      chk(done_o, 0);
      @(posedge clk_i) #1;
    end
    chk(done_o, 1);
  endtask : go
  task automatic t_pm;
    go(OP_MOVE_INDIRECT, 16'hffff, 3);
    chk(pm_addr_o, 16'h7fff);
    chk(acc_o, 8'ha5);
  endtask : t_pm
  task automatic t_dm;
    go(OP_MOVE_INDIRECT, 16'h0040, 2);
    chk(acc_o, 8'h3c);
  endtask : t_dm
  task automatic t_br;
    pc_i = 15'h7ff0;
    go(OP_BRANCH_REL, 16'h0000, 1);
    chk(pc_load_o, 1);
    chk(pc_target_o, 16'h002c);
  endtask : t_br
  task automatic t_wr;
    go(OP_WRITE_INDIRECT, 16'h8123, 1);
    go(OP_WRITE_INDIRECT, 16'h0041, 1);
  endtask : t_wr
  // enable low: a pending request must not be taken
  task automatic t_en;
    @(posedge clk_i) #1;
    en_i = 0;
    req_i = '{OP_MOVE_INDIRECT, 16'h8010, 8'h00};
    req_valid_i = 1;
    repeat (2) @(posedge clk_i);
    #1 chk(req_ready_o, 0);
    chk(pm_rd_o, 0);
    chk(done_o, 0);
    req_valid_i = 0;
    en_i = 1;
  endtask : t_en
  task automatic summarize;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  initial begin
    #1000;
    errors++;
    summarize;
  end
  initial begin
    repeat (5) @(posedge clk_i);
    #1 resetn_i = 1;
    t_pm;
    t_dm;
    t_br;
    t_wr;
    t_en;
    summarize;
  end
endmodule : program_memory_data_read_tb_top
bind program_memory_data_read pm_data_chk u_pm_data_chk (.*);
